// [cdg_generator.sv]
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Complementary waveform generator with dead band and shutdown override
module cdg_generator
  import cdg_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Waveform sources
  input  wire logic              modulator_one_output,
  input  wire logic              modulator_two_output,
  input  wire logic              oscillator_output,
  input  wire logic              logic_cell_output,
  // Dead-band clock reference and fault input
  input  wire logic              internal_fast_oscillator,
  input  wire logic              fault_input,
  // Output pins
  output logic                   primary_output,
  output logic                   primary_output_oe,
  output logic                   complementary_output,
  output logic                   complementary_output_oe
);

  // Control register 0
  logic                  module_enable_bit;
  logic                  primary_output_enable;
  logic                  complementary_output_enable;
  logic                  primary_polarity;
  logic                  complementary_polarity;
  logic                  deadband_clock_select;

  // Control register 1
  logic                  shutdown_state_flag;
  logic [1:0]            primary_override_level;
  logic [1:0]            complementary_override_level;
  logic [1:0]            input_source_select_field;

  // Control register 2
  logic                  auto_restart_enable;
  logic                  shutdown_on_fault;
  logic                  shutdown_on_logic_cell;

  // Delay registers
  logic [DB_W-1:0]       rising_delay_register;
  logic [DB_W-1:0]       falling_delay_register;

  // Register decode
  logic                  wr_con0;
  logic                  wr_con1;
  logic                  wr_con2;
  logic                  wr_dbr;
  logic                  wr_dbf;
  logic [DATA_W-1:0]     next_rdata;

  // Source path
  logic                  source_raw;
  logic                  source_sync1;
  logic                  source_sync2;
  logic                  source_prev;
  logic                  source_rise;
  logic                  source_fall;

  // Dead-band tick path
  logic                  osc_sync1;
  logic                  osc_sync2;
  logic                  osc_prev;
  logic                  db_tick;

  // Shutdown and waveform state
  logic                  fault_hit;
  logic                  enable_prev;
  logic                  timers_cancel;
  logic                  primary_active;
  logic                  complementary_active;
  logic                  next_primary_output;
  logic                  next_complementary_output;
  logic                  next_primary_oe;
  logic                  next_complementary_oe;

  // Register write decode

  // Address decode for writes; unmapped writes are dropped
  always_comb begin
    wr_con0 = 1'b0;
    wr_con1 = 1'b0;
    wr_con2 = 1'b0;
    wr_dbr  = 1'b0;
    wr_dbf  = 1'b0;
    if (reg_wr) begin
      if (reg_addr == OFS_CON0) begin
        wr_con0 = 1'b1;
      end else if (reg_addr == OFS_CON1) begin
        wr_con1 = 1'b1;
      end else if (reg_addr == OFS_CON2) begin
        wr_con2 = 1'b1;
      end else if (reg_addr == OFS_DBR) begin
        wr_dbr = 1'b1;
      end else if (reg_addr == OFS_DBF) begin
        wr_dbf = 1'b1;
      end
    end
  end

  // Control register 0: enables, polarities, clock select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_enable_bit           <= 1'b0;
      primary_output_enable       <= 1'b0;
      complementary_output_enable <= 1'b0;
      primary_polarity            <= 1'b0;
      complementary_polarity      <= 1'b0;
      deadband_clock_select       <= 1'b0;
    end else if (wr_con0) begin
      module_enable_bit           <= reg_wdata[CON0_EN];
      primary_output_enable       <= reg_wdata[CON0_OEA];
      complementary_output_enable <= reg_wdata[CON0_OEB];
      primary_polarity            <= reg_wdata[CON0_POLA];
      complementary_polarity      <= reg_wdata[CON0_POLB];
      deadband_clock_select       <= reg_wdata[CON0_CS];
    end
  end

  // Control register 1: override levels and source select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_override_level       <= 2'h0;
      complementary_override_level <= 2'h0;
      input_source_select_field    <= SRC_MOD1;
    end else if (wr_con1) begin
      primary_override_level       <= reg_wdata[CON1_LVLA_HI:CON1_LVLA_LO];
      complementary_override_level <= reg_wdata[CON1_LVLB_HI:CON1_LVLB_LO];
      input_source_select_field    <= reg_wdata[CON1_IS_HI:CON1_IS_LO];
    end
  end

  // Control register 2: shutdown sources and restart mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_restart_enable    <= 1'b0;
      shutdown_on_fault      <= 1'b0;
      shutdown_on_logic_cell <= 1'b0;
    end else if (wr_con2) begin
      auto_restart_enable    <= reg_wdata[CON2_ARSEN];
      shutdown_on_fault      <= reg_wdata[CON2_SDS_FLT];
      shutdown_on_logic_cell <= reg_wdata[CON2_SDS_LC];
    end
  end

  // Dead-band delay registers, low six bits only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rising_delay_register  <= DB_ZERO;
      falling_delay_register <= DB_ZERO;
    end else begin
      if (wr_dbr) begin
        rising_delay_register <= reg_wdata[DB_W-1:0];
      end
      if (wr_dbf) begin
        falling_delay_register <= reg_wdata[DB_W-1:0];
      end
    end
  end

  // Shutdown state

  // Level sensitive: a held fault keeps the block in shutdown
  assign fault_hit = (shutdown_on_fault      & fault_input)
                   | (shutdown_on_logic_cell & logic_cell_output);

  // A fault in the same cycle as a software clear keeps the flag set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_state_flag <= 1'b0;
    end else if (fault_hit) begin
      shutdown_state_flag <= 1'b1;
    end else if (wr_con1) begin
      shutdown_state_flag <= reg_wdata[CON1_ASD];
    end else if (auto_restart_enable) begin
      shutdown_state_flag <= 1'b0;
    end
  end

  // Source selection, synchronisation and edge detection

  // Source multiplexer ahead of the synchroniser
  always_comb begin
    case (input_source_select_field)
      SRC_MOD1: source_raw = modulator_one_output;
      SRC_MOD2: source_raw = modulator_two_output;
      SRC_OSC:  source_raw = oscillator_output;
      default:  source_raw = logic_cell_output;
    endcase
  end

  // Two-stage synchroniser plus one stage of history for edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      source_sync1 <= 1'b0;
      source_sync2 <= 1'b0;
      source_prev  <= 1'b0;
    end else begin
      source_sync1 <= source_raw;
      source_sync2 <= source_sync1;
      source_prev  <= source_sync2;
    end
  end

  // Edges are taken only from the second stage onward
  assign source_rise = source_sync2 & ~source_prev;
  assign source_fall = ~source_sync2 & source_prev;

  // Dead-band clock

  // Fast oscillator is sampled, so it must be slower than half core_clk
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      osc_prev  <= 1'b0;
    end else begin
      osc_sync1 <= internal_fast_oscillator;
      osc_sync2 <= osc_sync1;
      osc_prev  <= osc_sync2;
    end
  end

  // One tick per dead-band clock period
  assign db_tick = deadband_clock_select ? (osc_sync2 & ~osc_prev) : 1'b1;

  // Dead-band timers

  // Enable edge tracker so both drives start cleared on enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_prev <= 1'b0;
    end else begin
      enable_prev <= module_enable_bit;
    end
  end

  // Disabled, just enabled or shut down: both timers held off
  assign timers_cancel = ~module_enable_bit | ~enable_prev
                       | shutdown_state_flag;

  // Rising edge timer drives the primary; falling edge cancels it at once
  cdg_deadband_timer u_rise_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (source_rise),
    .cancel   (timers_cancel | source_fall),
    .tick     (db_tick),
    .delay    (rising_delay_register),
    .active   (primary_active)
  );

  // Falling edge timer drives the complement; rising edge cancels it at once
  cdg_deadband_timer u_fall_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (source_fall),
    .cancel   (timers_cancel | source_rise),
    .tick     (db_tick),
    .delay    (falling_delay_register),
    .active   (complementary_active)
  );

  // Output stage

  // Override levels bypass polarity; the waveform goes through it
  always_comb begin
    if (shutdown_state_flag) begin
      next_primary_output       = primary_override_level[LVL_VALUE];
      next_complementary_output = complementary_override_level[LVL_VALUE];
    end else begin
      next_primary_output       = ~(primary_active ^ primary_polarity);
      next_complementary_output = ~(complementary_active
                                    ^ complementary_polarity);
    end
  end

  // Pin enables gated by the module enable and the release code
  always_comb begin
    next_primary_oe       = module_enable_bit & primary_output_enable;
    next_complementary_oe = module_enable_bit & complementary_output_enable;
    if (shutdown_state_flag && primary_override_level[LVL_RELEASE]) begin
      next_primary_oe = 1'b0;
    end
    if (shutdown_state_flag && complementary_override_level[LVL_RELEASE]) begin
      next_complementary_oe = 1'b0;
    end
  end

  // Registered pins; both timers never overlap so neither is active together
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_output          <= 1'b0;
      complementary_output    <= 1'b0;
      primary_output_oe       <= 1'b0;
      complementary_output_oe <= 1'b0;
    end else begin
      primary_output          <= next_primary_output;
      complementary_output    <= next_complementary_output;
      primary_output_oe       <= next_primary_oe;
      complementary_output_oe <= next_complementary_oe;
    end
  end

  // Register read

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    next_rdata = DATA_ZERO;
    if (reg_rd) begin
      if (reg_addr == OFS_CON0) begin
        next_rdata[CON0_EN]   = module_enable_bit;
        next_rdata[CON0_OEA]  = primary_output_enable;
        next_rdata[CON0_OEB]  = complementary_output_enable;
        next_rdata[CON0_POLA] = primary_polarity;
        next_rdata[CON0_POLB] = complementary_polarity;
        next_rdata[CON0_CS]   = deadband_clock_select;
      end else if (reg_addr == OFS_CON1) begin
        next_rdata[CON1_ASD]                  = shutdown_state_flag;
        next_rdata[CON1_LVLB_HI:CON1_LVLB_LO] = complementary_override_level;
        next_rdata[CON1_LVLA_HI:CON1_LVLA_LO] = primary_override_level;
        next_rdata[CON1_IS_HI:CON1_IS_LO]     = input_source_select_field;
      end else if (reg_addr == OFS_DBR) begin
        next_rdata[DB_W-1:0] = rising_delay_register;
      end else if (reg_addr == OFS_DBF) begin
        next_rdata[DB_W-1:0] = falling_delay_register;
      end else if (reg_addr == OFS_CON2) begin
        next_rdata[CON2_ARSEN]   = auto_restart_enable;
        next_rdata[CON2_SDS_FLT] = shutdown_on_fault;
        next_rdata[CON2_SDS_LC]  = shutdown_on_logic_cell;
      end else if (reg_addr == OFS_STAT) begin
        next_rdata[STAT_SHDN]  = shutdown_state_flag;
        next_rdata[STAT_ACT_A] = primary_active;
        next_rdata[STAT_ACT_B] = complementary_active;
      end
    end
  end

  // Read data stands for one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= DATA_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : cdg_generator

`default_nettype wire

// [cdg_pkg.sv]
// Operation
// - The block drives a primary and a complementary output, both made from one chosen source.
// - A two-bit select picks the source from modulator one, modulator two, oscillator or logic cell.
// - One select bit times the dead band from the system clock or the 16 MHz fast oscillator.
// - When the block is switched on, both drive signals start out cleared.
// - Each output has its own enable, and with it clear the block leaves that pin alone.
// - With an output enabled, the pin gets either its override level or the live waveform.
// - With the block switched off, output enables and drive levels do nothing to the pins.
// - Each output has a polarity bit: set means active high, clear means active low.
// - Polarity applies to the live waveform only, never to the override levels.
// - Each output turns on only a dead time after the other output turned off.
// - Two separate 6-bit counters time the dead band after rising and after falling edges.
// - A dead band lasts from a count of zero up to the value in its delay register.
// - A rising source edge drops the complementary output at once and raises the primary after the rising delay.
// - A falling source edge drops the primary output at once and raises the complementary after the falling delay.
// - A delay value of zero switches the opposite output on at once.
// - Any selected shutdown input high forces both outputs to their override levels without software.
`timescale 1ns/100ps
`default_nettype none

package cdg_pkg;

  // Register port
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 8;
  localparam logic [2:0]  OFS_CON0      = 3'h0;
  localparam logic [2:0]  OFS_CON1      = 3'h1;
  localparam logic [2:0]  OFS_DBR       = 3'h2;
  localparam logic [2:0]  OFS_DBF       = 3'h3;
  localparam logic [2:0]  OFS_CON2      = 3'h4;
  localparam logic [2:0]  OFS_STAT      = 3'h5;
  localparam logic [7:0]  DATA_ZERO     = 8'h00;

  // Control register 0 fields
  localparam int          CON0_EN       = 7;
  localparam int          CON0_OEA      = 6;
  localparam int          CON0_OEB      = 5;
  localparam int          CON0_POLA     = 4;
  localparam int          CON0_POLB     = 3;
  localparam int          CON0_CS       = 0;

  // Control register 1 fields (waveform_input_shutdown_control)
  localparam int          CON1_ASD      = 7;
  localparam int          CON1_LVLB_HI  = 5;
  localparam int          CON1_LVLB_LO  = 4;
  localparam int          CON1_LVLA_HI  = 3;
  localparam int          CON1_LVLA_LO  = 2;
  localparam int          CON1_IS_HI    = 1;
  localparam int          CON1_IS_LO    = 0;

  // Control register 2 fields
  localparam int          CON2_ARSEN    = 2;
  localparam int          CON2_SDS_FLT  = 1;
  localparam int          CON2_SDS_LC   = 0;

  // Status register fields
  localparam int          STAT_SHDN     = 2;
  localparam int          STAT_ACT_A    = 1;
  localparam int          STAT_ACT_B    = 0;

  // Override level codes: bit 1 releases the pin, bit 0 is the level
  localparam int          LVL_RELEASE   = 1;
  localparam int          LVL_VALUE     = 0;

  // Input source codes
  localparam logic [1:0]  SRC_MOD1      = 2'h0;
  localparam logic [1:0]  SRC_MOD2      = 2'h1;
  localparam logic [1:0]  SRC_OSC       = 2'h2;
  localparam logic [1:0]  SRC_LC        = 2'h3;

  // Dead-band counters
  localparam int          DB_W          = 6;
  localparam logic [5:0]  DB_ZERO       = 6'h00;
  localparam logic [5:0]  DB_ONE        = 6'h01;

  typedef enum logic [1:0] {
    CDG_DB_IDLE = 2'b00,
    CDG_DB_WAIT = 2'b01,
    CDG_DB_ON   = 2'b10
  } cdg_db_state_e;

endpackage : cdg_pkg

// One dead-band timer: off until started, on after the programmed count
module cdg_deadband_timer
  import cdg_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            start,
  input  wire logic            cancel,
  input  wire logic            tick,
  input  wire logic [DB_W-1:0] delay,
  output logic                 active
);

  cdg_db_state_e   state;
  logic [DB_W-1:0] count;
  logic [DB_W-1:0] next_count;

  assign next_count = count + DB_ONE;

  // Cancel wins so the opposite edge always drops this output at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CDG_DB_IDLE;
      count <= DB_ZERO;
    end else if (cancel) begin
      state <= CDG_DB_IDLE;
      count <= DB_ZERO;
    end else if (start) begin
      count <= DB_ZERO;
      if (delay == DB_ZERO) begin
        state <= CDG_DB_ON;
      end else begin
        state <= CDG_DB_WAIT;
      end
    end else begin
      case (state)
        CDG_DB_WAIT: begin
          if (tick) begin
            count <= next_count;
            if (next_count == delay) begin
              state <= CDG_DB_ON;
            end
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  assign active = (state == CDG_DB_ON);

endmodule : cdg_deadband_timer

`default_nettype wire

// [cdg_generator_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// Pin checks against control values shadowed from the register port
module cdg_generator_sva
  import cdg_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              modulator_one_output,
  input wire logic              fault_input,
  input wire logic              primary_output,
  input wire logic              primary_output_oe,
  input wire logic              complementary_output,
  input wire logic              complementary_output_oe
);
  logic [7:0] shd [8];
  logic       sd_seen;
  // Shadow of every written register, taken at the writing edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) shd[i] <= 8'h00;
    end else if (reg_wr) begin
      shd[reg_addr] <= reg_wdata;
    end
  end
  // Sticky: override levels may mimic an overlap, so that check stands down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sd_seen <= 1'h0;
    else if (fault_input || shd[OFS_CON2][CON2_SDS_LC] || shd[OFS_CON1][CON1_ASD])
      sd_seen <= 1'h1;
  end
  // Decoded controls; pins lag them by one edge
  wire logic en_m  = shd[OFS_CON0][CON0_EN];
  wire logic oea_m = shd[OFS_CON0][CON0_OEA];
  wire logic pa_m  = shd[OFS_CON0][CON0_POLA];
  wire logic pb_m  = shd[OFS_CON0][CON0_POLB];
  wire logic run_m = en_m && oea_m && shd[OFS_CON0][CON0_OEB]
                     && shd[OFS_CON1][1:0] == SRC_MOD1 && !sd_seen;
  wire logic sys_m = run_m && !shd[OFS_CON0][CON0_CS];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_off_disabled: assert property (!$past(en_m) |-> !primary_output_oe && !complementary_output_oe)
    else $error("pin driven while block off");
  a_oe_primary: assert property (!$past(oea_m) |-> !primary_output_oe)
    else $error("primary driven with its enable clear");
  // A source edge seen here reaches the pins three edges later, visible one edge after that
  a_no_overlap: assert property (
    (primary_output_oe && complementary_output_oe && !sd_seen)
    |-> !(primary_output == $past(pa_m) && complementary_output == $past(pb_m)))
    else $error("both outputs active");
  a_ovr_primary: assert property (
    (fault_input && shd[OFS_CON2][CON2_SDS_FLT] && en_m && oea_m
    && !shd[OFS_CON1][CON1_LVLA_HI]) |-> ##2 primary_output_oe
    && primary_output == shd[OFS_CON1][CON1_LVLA_LO])
    else $error("override level not on primary");
  a_rise_off: assert property (
    run_m && $rose(modulator_one_output) |-> ##4 complementary_output != pb_m)
    else $error("complementary not dropped on rise");
  a_fall_off: assert property (
    run_m && $fell(modulator_one_output) |-> ##4 primary_output != pa_m)
    else $error("primary not dropped on fall");
  a_zero_rise: assert property (
    sys_m && shd[OFS_DBR][5:0] == 6'h00 && $rose(modulator_one_output)
    |-> ##4 primary_output == pa_m && complementary_output != pb_m)
    else $error("zero delay rise late");
  a_rise_count: assert property (
    sys_m && shd[OFS_DBR][5:0] == 6'h02 && $rose(modulator_one_output)
    |-> ##4 (primary_output != pa_m) [*2] ##1 primary_output == pa_m)
    else $error("rise delay of two wrong");
endmodule : cdg_generator_sva
bind cdg_generator cdg_generator_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .modulator_one_output(modulator_one_output), .fault_input(fault_input),
  .primary_output(primary_output), .primary_output_oe(primary_output_oe),
  .complementary_output(complementary_output), .complementary_output_oe(complementary_output_oe));
`default_nettype wire

// [cdg_switch_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Two power switches fed by the pins; a released pin leaves its switch off
module cdg_switch_model (
  input  wire logic core_clk,
  input  wire logic pin_a,
  input  wire logic oe_a,
  input  wire logic pin_b,
  input  wire logic oe_b,
  input  wire logic act_a,
  input  wire logic act_b,
  output var  logic overlap_seen
);
  wire logic on_a = oe_a && (pin_a == act_a);
  wire logic on_b = oe_b && (pin_b == act_b);
  // Sticky, so a one-cycle shoot-through is not lost between checks
  initial overlap_seen = 1'h0;
  always @(posedge core_clk) if (on_a && on_b) overlap_seen <= 1'h1;
endmodule : cdg_switch_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cdg_pkg::*;
  logic              core_clk = 1'h0;
  logic              rst_n = 1'h0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'h0;
  logic              reg_rd = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic [3:0]        src = 4'h0;
  logic              osc = 1'h0;
  logic              fault_input = 1'h0;
  logic              po, poe, co, coe, ovl;
  logic              pa = 1'h1;
  logic              pb = 1'h1;
  int                bad_count = 0;
  int                total_checks = 0;
  int                cyc = 0;
  int                n;
  // Core clock and an unrelated fast oscillator
  always #5 core_clk = ~core_clk;
  always #31.25 osc = ~osc;
  cdg_generator u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .modulator_one_output(src[0]), .modulator_two_output(src[1]),
    .oscillator_output(src[2]), .logic_cell_output(src[3]),
    .internal_fast_oscillator(osc), .fault_input(fault_input),
    .primary_output(po), .primary_output_oe(poe),
    .complementary_output(co), .complementary_output_oe(coe));
  cdg_switch_model u_sw (.core_clk(core_clk), .pin_a(po), .oe_a(poe), .pin_b(co),
    .oe_b(coe), .act_a(pa), .act_b(pb), .overlap_seen(ovl));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata & m, exp);
  endtask
  // Counts edges until the chosen pin shows the level, bounded
  task automatic wait_pin(input logic want_a, input logic lvl);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while ((want_a ? po : co) !== lvl && n < 100);
  endtask
  task automatic edge_run(input logic [1:0] s, input logic [5:0] r, input logic [5:0] f);
    wr(OFS_DBR, {2'h0, r});
    wr(OFS_DBF, {2'h0, f});
    wr(OFS_CON1, {6'h00, s});
    repeat (4) @(posedge core_clk);
    src[s] <= 1'h1;
    wait_pin(1'h1, 1'h1);
    check(n[7:0], 8'h04 + r);
    check({7'h00, co}, 8'h00);
    @(posedge core_clk) src[s] <= 1'h0;
    wait_pin(1'h0, 1'h1);
    check(n[7:0], 8'h04 + f);
    check({7'h00, po}, 8'h00);
  endtask
  task automatic s_edges;
    logic [1:0] s [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [5:0] r [5] = '{6'h00, 6'h02, 6'h01, 6'h3F, 6'h05};
    logic [5:0] f [5] = '{6'h3F, 6'h00, 6'h04, 6'h02, 6'h01};
    for (int i = 0; i < 5; i++) edge_run(s[i], r[i], f[i]);
  endtask
  task automatic s_enables;
    wr(OFS_CON0, 8'hB8);
    repeat (2) @(posedge core_clk);
    #1 check({6'h00, poe, coe}, 8'h01);
    wr(OFS_CON0, 8'h78);
    repeat (2) @(posedge core_clk);
    #1 check({6'h00, poe, coe}, 8'h00);
  endtask
  // Switch polarity before enabling so the model never sees a false overlap
  task automatic s_fast;
    pa = 1'h0;
    pb = 1'h0;
    wr(OFS_CON0, 8'hE1);
    wr(OFS_CON1, 8'h00);
    wr(OFS_DBR, 8'h04);
    repeat (2) @(posedge core_clk);
    #1 check({6'h00, po, co}, 8'h03);
    @(posedge core_clk) src[0] <= 1'h1;
    wait_pin(1'h1, 1'h0);
    check({7'h00, n >= 22 && n <= 36}, 8'h01);
    check({7'h00, co}, 8'h01);
  endtask
  task automatic s_shutdown;
    wr(OFS_CON2, 8'h02);
    wr(OFS_CON1, 8'h24);
    @(posedge core_clk) fault_input <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1 check({5'h00, po, poe, coe}, 8'h06);
    rd(OFS_STAT, 8'h04, 8'h04);
    @(posedge core_clk) fault_input <= 1'h0;
    wr(OFS_CON1, 8'h24);
    rd(OFS_STAT, 8'h04, 8'h00);
    // Auto restart drops the flag once the fault is gone
    wr(OFS_CON2, 8'h06);
    @(posedge core_clk) fault_input <= 1'h1;
    rd(OFS_STAT, 8'h04, 8'h04);
    @(posedge core_clk) fault_input <= 1'h0;
    rd(OFS_STAT, 8'h04, 8'h00);
  endtask
  // Cut a hang short far beyond the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic s_regs;
    for (int a = 0; a < 7; a++) rd(a[2:0], 8'hFF, 8'h00);
    wr(OFS_DBR, 8'hFF);
    rd(OFS_DBR, 8'hFF, 8'h3F);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'hFF, 8'h00);
    wr(OFS_CON0, 8'hF8);
    repeat (3) @(posedge core_clk);
    #1 check({6'h00, po, co}, 8'h00);
    check({6'h00, poe, coe}, 8'h03);
  endtask
  // Second reset in mid-run must clear control register 1 again
  task automatic s_reset;
    @(posedge core_clk) rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(OFS_CON1, 8'hFF, 8'h00);
    check({7'h00, ovl}, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'h1;
    s_regs();
    s_edges();
    s_enables();
    s_fast();
    s_shutdown();
    s_reset();
    complete_run();
  end
endmodule : tb
`default_nettype wire
